// >>> tcm_pkg.sv
package tcm_pkg;

  // ---------------------------------------------------------------
  // sizes and defaults
  // ---------------------------------------------------------------
  localparam int TCM_NUM_MATCH = 4;   // match channels per counter
  localparam int TCM_WIDE_W = 32;     // wide variant counter width
  localparam int TCM_NARROW_W = 16;   // narrow variant counter width
  localparam int TCM_WIDE_NCAP = 4;   // capture channels, wide variant
  localparam int TCM_NARROW_NCAP = 3; // capture channels, narrow variant
  localparam int TCM_DEF_PINS = 2;    // pins that may feed one function

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic TCM_RST_MATCH_OUT = 1'b0; // match outputs after reset
  localparam logic TCM_RST_PIN = 1'b0;       // synchroniser start level

  // ---------------------------------------------------------------
  // counting modes and match pin actions
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TCM_TIMER   = 2'b00,  // count core clock cycles
    TCM_EV_RISE = 2'b01,  // count rising edges of the event input
    TCM_EV_FALL = 2'b10,  // count falling edges
    TCM_EV_BOTH = 2'b11   // count both edges
  } tcm_mode_t;

  typedef enum logic [1:0] {
    TCM_ACT_NONE   = 2'b00, // leave pin as it is
    TCM_ACT_LOW    = 2'b01, // drive low on match
    TCM_ACT_HIGH   = 2'b10, // drive high on match
    TCM_ACT_TOGGLE = 2'b11  // invert on match
  } tcm_act_t;

  // ---------------------------------------------------------------
  // per-channel configuration carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic irq;       // raise a pulse on match
    logic stop;      // halt counting on match
    logic rst;       // clear counter at next advance after match
    tcm_act_t act;   // external pin action
  } tcm_match_cfg_t;

  typedef struct packed {
    logic rise;      // capture on rising edge
    logic fall;      // capture on falling edge
    logic irq;       // raise a pulse on capture
    logic and_comb;  // 1: and of enabled pins, 0: or
  } tcm_cap_cfg_t;

endpackage

// >>> tcm_timer.sv
`timescale 1ns/1ps
module tcm_timer
  import tcm_pkg::*;
#(
  parameter int WIDTH = TCM_WIDE_W,   // counter and prescaler width
  parameter int NCAP = TCM_WIDE_NCAP, // capture channels
  parameter int PINS = TCM_DEF_PINS   // pins per capture/match function
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_counter_clear,
  input wire tcm_mode_t i_mode,
  input wire logic [1:0] i_event_sel,
  input wire logic [WIDTH-1:0] i_prescale_limit,
  input wire logic [TCM_NUM_MATCH-1:0][WIDTH-1:0] i_match_val,
  input wire tcm_match_cfg_t [TCM_NUM_MATCH-1:0] i_match_cfg,
  input wire logic [TCM_NUM_MATCH-1:0][PINS-1:0] i_match_pin_en,
  input wire tcm_cap_cfg_t [NCAP-1:0] i_cap_cfg,
  input wire logic [NCAP-1:0][PINS-1:0] i_cap_pin_en,
  input wire logic [NCAP-1:0][PINS-1:0] i_cap_pin,
  output logic [WIDTH-1:0] o_count,
  output logic [WIDTH-1:0] o_prescale_count,
  output logic o_stopped,
  output logic [NCAP-1:0][WIDTH-1:0] o_cap_val,
  output logic [NCAP-1:0] o_cap_irq,
  output logic [NCAP-1:0] o_cap_edge,
  output logic [TCM_NUM_MATCH-1:0] o_match_irq,
  output logic [TCM_NUM_MATCH-1:0] o_match_out,
  output logic [TCM_NUM_MATCH-1:0][PINS-1:0] o_match_pin
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (WIDTH < 2 || WIDTH > 32)
  begin : g_bad_width
    $error("tcm_timer: WIDTH must be 2 to 32");
  end
  if (NCAP < 1 || NCAP > 4)
  begin : g_bad_ncap
    $error("tcm_timer: NCAP must be 1 to 4");
  end
  if (PINS < 1)
  begin : g_bad_pins
    $error("tcm_timer: PINS must be at least 1");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // edge of interest between a previous and current level
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rise, input logic fall);
    edge_hit = (rise && !prev && cur) || (fall && prev && !cur);
  endfunction

  // fold the enabled pins of one function into one level
  function automatic logic pin_fold(input logic [PINS-1:0] lvl,
                                    input logic [PINS-1:0] en,
                                    input logic and_mode);
    if (and_mode)
      pin_fold = (&(lvl | ~en)) && (|en);
    else
      pin_fold = |(lvl & en);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NCAP-1:0][PINS-1:0] s1_r, s2_r, s3_r; // three-stage chain
  logic [NCAP-1:0][PINS-1:0] flt_r, flt_nxt;   // accepted level
  logic [NCAP-1:0] comb_r, comb_nxt;           // previous folded level

  // a change counts only once stages two and three agree
  always_comb
  begin
    flt_nxt = flt_r;
    for (int c = 0; c < NCAP; c++)
    begin
      for (int p = 0; p < PINS; p++)
      begin
        if (s2_r[c][p] == s3_r[c][p])
          flt_nxt[c][p] = s3_r[c][p];
      end
    end
  end

  // fold pins per channel; or/and combining of inputs
  always_comb
  begin
    for (int c = 0; c < NCAP; c++)
      comb_nxt[c] = pin_fold(flt_r[c], i_cap_pin_en[c],
                             i_cap_cfg[c].and_comb);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_r <= {(NCAP * PINS){TCM_RST_PIN}};
      s2_r <= {(NCAP * PINS){TCM_RST_PIN}};
      s3_r <= {(NCAP * PINS){TCM_RST_PIN}};
      flt_r <= {(NCAP * PINS){TCM_RST_PIN}};
      comb_r <= '0;
    end
    else
    begin
      s1_r <= i_cap_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
      comb_r <= comb_nxt;
    end
  end

  // ---------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------
  logic tick;              // one prescaler input tick
  logic ev_level_prev;     // selected channel, last cycle
  logic ev_level_now;      // selected channel, this cycle
  logic sel_ok;            // selected channel exists

  // timer counts every clock, event mode counts input edges; a pulse
  // shorter than two clock periods may be missed by the filter
  always_comb
  begin
    sel_ok = (32'(i_event_sel) < NCAP);
    ev_level_prev = 1'b0;
    ev_level_now = 1'b0;
    for (int c = 0; c < NCAP; c++)
    begin
      if (32'(i_event_sel) == c)
      begin
        ev_level_prev = comb_r[c];
        ev_level_now = comb_nxt[c];
      end
    end
    case (i_mode)
      TCM_TIMER: tick = 1'b1;
      TCM_EV_RISE: tick = sel_ok &&
        edge_hit(ev_level_prev, ev_level_now, 1'b1, 1'b0);
      TCM_EV_FALL: tick = sel_ok &&
        edge_hit(ev_level_prev, ev_level_now, 1'b0, 1'b1);
      TCM_EV_BOTH: tick = sel_ok &&
        edge_hit(ev_level_prev, ev_level_now, 1'b1, 1'b1);
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // prescaler, counter and match detection
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] pc_r, pc_nxt;   // prescale count
  logic [WIDTH-1:0] tc_r, tc_nxt;   // main count
  logic stop_r, stop_nxt;           // halted by a match
  logic run;                        // counting allowed
  logic adv;                        // main counter advances
  logic wrap;                       // a reset-on-match is pending
  logic [TCM_NUM_MATCH-1:0] mev;    // match events this cycle

  always_comb
  begin
    run = i_enable && !stop_r;
    pc_nxt = pc_r;
    tc_nxt = tc_r;
    adv = 1'b0;
    wrap = 1'b0;
    mev = '0;
    for (int m = 0; m < TCM_NUM_MATCH; m++)
    begin
      if (i_match_cfg[m].rst && tc_r == i_match_val[m])
        wrap = 1'b1;
    end
    if (i_counter_clear)
    begin
      pc_nxt = '0;
      tc_nxt = '0;
    end
    else if (run && tick)
    begin
      // prescaler restarts when it reaches its limit
      if (pc_r >= i_prescale_limit)
      begin
        pc_nxt = '0;
        adv = 1'b1;
        // clear at advance after match, else free run
        tc_nxt = wrap ? '0 : tc_r + 1'b1;
      end
      else
        pc_nxt = pc_r + 1'b1;
    end
    // counter compared to every match value on load
    for (int m = 0; m < TCM_NUM_MATCH; m++)
      mev[m] = adv && (tc_nxt == i_match_val[m]);
    // a stop match halts until enable is dropped
    stop_nxt = stop_r && i_enable;
    for (int m = 0; m < TCM_NUM_MATCH; m++)
    begin
      if (mev[m] && i_match_cfg[m].stop)
        stop_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pc_r <= '0;
      tc_r <= '0;
      stop_r <= 1'b0;
    end
    else
    begin
      pc_r <= pc_nxt;
      tc_r <= tc_nxt;
      stop_r <= stop_nxt;
    end
  end

  // ---------------------------------------------------------------
  // match outputs and interrupt pulses
  // ---------------------------------------------------------------
  logic [TCM_NUM_MATCH-1:0] mout_r, mout_nxt;          // pin state
  logic [TCM_NUM_MATCH-1:0][PINS-1:0] mpin_r, mpin_nxt; // broadcast
  logic [TCM_NUM_MATCH-1:0] mirq_r, mirq_nxt;          // irq pulses

  always_comb
  begin
    mout_nxt = mout_r;
    for (int m = 0; m < TCM_NUM_MATCH; m++)
    begin
      mirq_nxt[m] = mev[m] && i_match_cfg[m].irq;
      if (mev[m])
      begin
        case (i_match_cfg[m].act)
          TCM_ACT_LOW: mout_nxt[m] = 1'b0;
          TCM_ACT_HIGH: mout_nxt[m] = 1'b1;
          TCM_ACT_TOGGLE: mout_nxt[m] = !mout_r[m];
          default: mout_nxt[m] = mout_r[m];
        endcase
      end
      // one output copied to every enabled pin
      mpin_nxt[m] = {PINS{mout_nxt[m]}} & i_match_pin_en[m];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mout_r <= {TCM_NUM_MATCH{TCM_RST_MATCH_OUT}};
      mpin_r <= '0;
      mirq_r <= '0;
    end
    else
    begin
      mout_r <= mout_nxt;
      mpin_r <= mpin_nxt;
      mirq_r <= mirq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // capture channels
  // ---------------------------------------------------------------
  logic [NCAP-1:0][WIDTH-1:0] cap_r, cap_nxt;  // snapshots
  logic [NCAP-1:0] cirq_r, cirq_nxt;           // capture irq pulses
  logic [NCAP-1:0] cedge_r, cedge_nxt;         // raw edge, ext irq use
  logic [NCAP-1:0] chit;                       // capture this cycle

  // every channel captures even while one drives counting
  always_comb
  begin
    cap_nxt = cap_r;
    for (int c = 0; c < NCAP; c++)
    begin
      chit[c] = edge_hit(comb_r[c], comb_nxt[c],
                         i_cap_cfg[c].rise, i_cap_cfg[c].fall);
      if (chit[c])
        cap_nxt[c] = tc_r;
      cirq_nxt[c] = chit[c] && i_cap_cfg[c].irq;
      cedge_nxt[c] = comb_r[c] != comb_nxt[c];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cap_r <= '0;
      cirq_r <= '0;
      cedge_r <= '0;
    end
    else
    begin
      cap_r <= cap_nxt;
      cirq_r <= cirq_nxt;
      cedge_r <= cedge_nxt;
    end
  end

  assign o_count = tc_r;
  assign o_prescale_count = pc_r;
  assign o_stopped = stop_r;
  assign o_cap_val = cap_r;
  assign o_cap_irq = cirq_r;
  assign o_cap_edge = cedge_r;
  assign o_match_irq = mirq_r;
  assign o_match_out = mout_r;
  assign o_match_pin = mpin_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  a_count_advance: assert property (
    (adv && !wrap) |=> (tc_r == $past(tc_r) + 1'b1))
    else $error("counter did not advance by one");
  a_prescale_wrap: assert property (
    (run && tick && !i_counter_clear && pc_r >= i_prescale_limit)
    |=> (pc_r == '0))
    else $error("prescaler did not restart");
  a_prescale_hold: assert property (
    (!i_counter_clear && pc_r < i_prescale_limit) |=> $stable(tc_r))
    else $error("counter moved before prescale limit");
  a_capture_load: assert property (
    chit[0] |=> (o_cap_val[0] == $past(tc_r)) && o_cap_irq[0] ==
    $past(i_cap_cfg[0].irq))
    else $error("capture did not latch count");
  a_match_pin_high: assert property (
    (mev[0] && i_match_cfg[0].act == TCM_ACT_HIGH) |=> o_match_out[0])
    else $error("match pin not driven high");
  a_match_toggle: assert property (
    (mev[0] && i_match_cfg[0].act == TCM_ACT_TOGGLE)
    |=> (o_match_out[0] != $past(o_match_out[0])))
    else $error("match pin did not toggle");
  a_stop_halts: assert property (
    (mev[1] && i_match_cfg[1].stop && i_enable && !i_counter_clear)
    |=> o_stopped ##1 ($past(i_counter_clear) || $stable(tc_r)))
    else $error("stop match did not halt counter");
  a_reset_wrap: assert property (
    (adv && wrap) |=> (tc_r == '0))
    else $error("reset match did not clear counter");
  a_match_irq: assert property (
    (mev[2] && i_match_cfg[2].irq) |=> o_match_irq[2] ##1
    (!o_match_irq[2] || $past(mev[2])))
    else $error("match pulse wrong");
  a_match_seen: assert property (
    (adv && tc_nxt == i_match_val[0] && i_match_cfg[0].irq)
    |=> o_match_irq[0])
    else $error("match not detected");

endmodule

// >>> tcm_pin_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far side: capture pin sources
// ---------------------------------------------------------------
module tcm_pin_model
  import tcm_pkg::*;
#(
  parameter int NCAP = TCM_WIDE_NCAP, // capture channels
  parameter int PINS = TCM_DEF_PINS   // pins per channel
)(
  input wire logic i_core_clk,
  output logic [NCAP-1:0][PINS-1:0] o_pins
);
  // pins idle low, driven the whole time, so never left floating
  initial o_pins = '0;

  // each level is held three clocks, longer than the two clock minimum
  // so every pulse is seen by the synchroniser chain
  task automatic pulse(input int ch, input logic [PINS-1:0] mask,
                       input int cnt);
    repeat (cnt)
    begin
      @(negedge i_core_clk);
      o_pins[ch] = mask;
      repeat (3) @(negedge i_core_clk);
      o_pins[ch] = '0;
      repeat (3) @(negedge i_core_clk);
    end
  endtask
endmodule

// >>> tcm_timer_bench.sv
`timescale 1ns/1ps
module tcm_timer_bench;
  import tcm_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic core_clk;
  logic resetn = 1'b0;
  logic enable = 1'b1;
  logic counter_clear = 1'b0;
  tcm_mode_t mode = TCM_TIMER;
  logic [1:0] event_sel = 2'h0;
  logic [31:0] limit = 32'h0;
  logic [3:0][31:0] mval = {4{32'hffff_ffff}}; // never reached
  tcm_match_cfg_t [3:0] mcfg = '0;
  logic [3:0][1:0] mpin_en = {4{2'h3}}; // broadcast to both pins
  tcm_cap_cfg_t [3:0] ccfg = '0;
  logic [3:0][1:0] cpin_en = '0;
  logic [3:0][1:0] pins;
  logic [31:0] count, pcount;
  logic stopped;
  logic [3:0][31:0] cap_val;
  logic [3:0] cap_irq, cap_edge, match_irq, match_out;
  logic [3:0][1:0] match_pin;
  int bad_count = 0;
  int checked = 0;
  int cap_irqs = 0;
  int cap_edges = 0;
  logic [3:0][15:0] nmval = {4{16'hffff}}; // narrow match, never reached
  logic [15:0] ncount;
  logic [2:0][15:0] ncap_val;

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  tcm_pin_model pm_u (.i_core_clk(core_clk), .o_pins(pins));

  tcm_timer dut_u (
    .i_core_clk(core_clk), .i_resetn(resetn), .i_enable(enable),
    .i_counter_clear(counter_clear), .i_mode(mode),
    .i_event_sel(event_sel), .i_prescale_limit(limit),
    .i_match_val(mval), .i_match_cfg(mcfg), .i_match_pin_en(mpin_en),
    .i_cap_cfg(ccfg), .i_cap_pin_en(cpin_en), .i_cap_pin(pins),
    .o_count(count), .o_prescale_count(pcount), .o_stopped(stopped),
    .o_cap_val(cap_val), .o_cap_irq(cap_irq), .o_cap_edge(cap_edge),
    .o_match_irq(match_irq), .o_match_out(match_out),
    .o_match_pin(match_pin)
  );

  // narrow variant, fed the same stimulus as the wide one except match values, which stay at nmval
  tcm_timer #(
    .WIDTH(TCM_NARROW_W),
    .NCAP(TCM_NARROW_NCAP),
    .PINS(2)
  ) narrow_u (
    .i_core_clk(core_clk), .i_resetn(resetn), .i_enable(enable),
    .i_counter_clear(counter_clear), .i_mode(mode),
    .i_event_sel(event_sel), .i_prescale_limit(limit[15:0]),
    .i_match_val(nmval), .i_match_cfg(mcfg), .i_match_pin_en(mpin_en),
    .i_cap_cfg(ccfg[2:0]), .i_cap_pin_en(cpin_en[2:0]),
    .i_cap_pin(pins[2:0]),
    .o_count(ncount), .o_prescale_count(), .o_stopped(),
    .o_cap_val(ncap_val), .o_cap_irq(), .o_cap_edge(),
    .o_match_irq(), .o_match_out(), .o_match_pin()
  );

  // capture pulses last one cycle, so they are tallied here; the
  // falling edge keeps the sample away from the launching edge
  always @(negedge core_clk)
  begin
    if (cap_irq[1] === 1'b1)
      cap_irqs++;
    if (cap_edge[1] === 1'b1)
      cap_edges++;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one clock of clear, then in timer mode every following edge is a tick
  task automatic clr();
    counter_clear = 1'b1;
    step(1);
    counter_clear = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_prescale();
    limit = 32'h2;
    clr();
    step(9);
    chk("count_prescaled", 32'h3, count);
    chk("prescale_wrapped", 32'h0, pcount);
    chk("narrow_count", 32'h3, ncount);
    step(1);
    chk("prescale_step", 32'h1, pcount);
    limit = 32'h0;
  endtask

  task automatic t_match_acts();
    tcm_act_t acts[5] = '{TCM_ACT_HIGH, TCM_ACT_TOGGLE, TCM_ACT_TOGGLE,
                          TCM_ACT_LOW, TCM_ACT_NONE};
    logic lvl[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic prev;
    prev = 1'b0;
    mval[0] = 32'h5;
    for (int k = 0; k < 5; k++)
    begin
      mcfg[0] = '{(k % 2 == 0), 1'b0, 1'b0, acts[k]};
      clr();
      step(4);
      chk("out_before", prev, match_out[0]);
      step(1);
      chk("out_level", lvl[k], match_out[0]);
      chk("out_pins", {2{lvl[k]}}, match_pin[0]);
      chk("match_irq", (k % 2 == 0), match_irq[0]);
      step(1);
      chk("irq_pulse", 1'b0, match_irq[0]);
      chk("runs_on", 32'h6, count);
      prev = lvl[k];
    end
    mcfg[0] = '0;
    mval[0] = 32'hffff_ffff;
  endtask

  task automatic t_match_stop();
    logic [31:0] held;
    mval[1] = 32'h4;
    mcfg[1] = '{1'b1, 1'b1, 1'b0, TCM_ACT_NONE};
    clr();
    step(4);
    chk("stop_irq", 1'b1, match_irq[1]);
    step(1);
    chk("stopped", 1'b1, stopped);
    chk("stop_near", 32'h4, count);
    held = count;
    step(8);
    chk("stop_frozen", held, count);
    enable = 1'b0;
    step(1);
    chk("stop_cleared", 1'b0, stopped);
    enable = 1'b1;
    mcfg[1] = '0;
    mval[1] = 32'hffff_ffff;
  endtask

  task automatic t_match_reset();
    mval[2] = 32'h3;
    mcfg[2] = '{1'b1, 1'b0, 1'b1, TCM_ACT_NONE};
    clr();
    step(3);
    chk("reset_hit", 32'h3, count);
    chk("reset_irq", 1'b1, match_irq[2]);
    step(1);
    chk("reset_zero", 32'h0, count);
    step(4);
    chk("reset_again", 32'h0, count);
    mcfg[2] = '0;
    mval[2] = 32'hffff_ffff;
  endtask

  task automatic t_event_capture();
    tcm_mode_t modes[3] = '{TCM_EV_RISE, TCM_EV_FALL, TCM_EV_BOTH};
    logic [31:0] exp[3] = '{32'h3, 32'h3, 32'h6};
    cpin_en[0] = 2'h1;
    cpin_en[1] = 2'h3;
    ccfg[1] = '{1'b1, 1'b0, 1'b1, 1'b0};
    // the event channel also captures its own rising edges
    ccfg[0] = '{1'b1, 1'b0, 1'b0, 1'b0};
    for (int k = 0; k < 3; k++)
    begin
      mode = modes[k];
      clr();
      pm_u.pulse(0, 2'h1, 3);
      step(6);
      chk("event_count", exp[k], count);
    end
    mode = TCM_EV_RISE;
    clr();
    pm_u.pulse(0, 2'h1, 3);
    pm_u.pulse(1, 2'h2, 1);
    step(6);
    chk("cap_or", 32'h3, cap_val[1]);
    chk("cap_irqs", 32'h1, cap_irqs);
    chk("cap_event_ch", 32'h2, cap_val[0]);
    chk("narrow_cap", 32'h3, ncap_val[1]);
    pm_u.pulse(0, 2'h1, 2);
    ccfg[1].and_comb = 1'b1;
    pm_u.pulse(1, 2'h2, 1);
    step(6);
    chk("cap_and_one", 32'h3, cap_val[1]);
    pm_u.pulse(1, 2'h3, 1);
    step(6);
    chk("cap_and_all", 32'h5, cap_val[1]);
    chk("cap_irqs_and", 32'h2, cap_irqs);
    chk("cap_edges", 32'h4, cap_edges);
    mode = TCM_TIMER;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    step(12);
    // timer mode counts from the first edge, so look while held
    chk("count_reset", 32'h0, count);
    chk("out_reset", 32'h0, match_out);
    resetn = 1'b1;
    t_prescale();
    t_match_acts();
    t_match_stop();
    t_match_reset();
    t_event_capture();
    complete_run();
  end

  // the tests need well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule
